// ==== inc/dnr_pkg.sv ====
// Behaviour
// RULE1: Type 01 in the low byte of the head word registers a user monitor name.
// RULE2: Monitor selectors 0x28, 0x29 and 0x2a pick user monitors one, two and three.
// RULE3: A monitor command with any other selector answers error 4100 and stores nothing.
// RULE4: Type 0x81 erases the chosen monitor name so the monitor shows its normal value.
// RULE5: Up to 16 characters come from words one to eight, odd character in the low byte.
// RULE6: Monitor and error names show at most their first 12 characters on the panel.
// RULE7: Type 02 registers a user error name for error numbers 0x10 to 0x14.
// RULE8: An error name command with a selector outside 0x10 to 0x14 answers error 4100.
// RULE9: Type 0x82 erases the user error name picked by the selector.
// RULE10: Writing 16 to 20 into the user error trigger word raises that user error.
// RULE11: Type 03 registers a user parameter name, selectors 1 to 10 for parameters one to ten.
// RULE12: A parameter name command with a selector outside 1 to 10 answers error 4101.
// RULE13: Type 0x83 erases the user parameter name picked by the selector.
// RULE14: Parameter names show at most their first 9 characters on the panel.
// RULE15: The caller sets the monitor select settings to 40, 41 and 42 before names appear.
// RULE16: Any type other than 01 to 04 or 0x81 to 0x84 answers error 4100.
// RULE17: Bit 7 of the type byte asks for a clear, bits 6 to 0 give the type; clears ignore text.
package dnr_pkg;

	// ------------------------------------------------------------
	// Command encoding
	// ------------------------------------------------------------
	localparam logic [6:0]  TYPE_MONITOR   = 7'h01;
	localparam logic [6:0]  TYPE_ERROR     = 7'h02;
	localparam logic [6:0]  TYPE_PARAM     = 7'h03;
	localparam logic [6:0]  TYPE_UNIT      = 7'h04;
	localparam int          CLEAR_BIT      = 7;
	localparam logic [7:0]  MON_SEL_FIRST  = 8'h28;
	localparam logic [7:0]  MON_SEL_LAST   = 8'h2a;
	localparam logic [7:0]  ERR_SEL_FIRST  = 8'h10;
	localparam logic [7:0]  ERR_SEL_LAST   = 8'h14;
	localparam logic [7:0]  PAR_SEL_FIRST  = 8'h01;
	localparam logic [7:0]  PAR_SEL_LAST   = 8'h0a;
	localparam logic [15:0] ERR_CODE_SEL   = 16'h1004;	// 4100 decimal
	localparam logic [15:0] ERR_CODE_PAR   = 16'h1005;	// 4101 decimal

	// ------------------------------------------------------------
	// Name storage layout
	// ------------------------------------------------------------
	localparam int          NUM_ENTRIES    = 18;
	localparam logic [4:0]  IDX_MON_BASE   = 5'h00;
	localparam logic [4:0]  IDX_ERR_BASE   = 5'h03;
	localparam logic [4:0]  IDX_PAR_BASE   = 5'h08;
	localparam int          MAX_CHARS      = 16;
	localparam logic [4:0]  SHOW_MON_ERR   = 5'h0c;	// 12 characters
	localparam logic [4:0]  SHOW_PAR       = 5'h09;	// 9 characters

	// ------------------------------------------------------------
	// Panel read kinds
	// ------------------------------------------------------------
	localparam logic [1:0]  KIND_MONITOR   = 2'h0;
	localparam logic [1:0]  KIND_ERROR     = 2'h1;
	localparam logic [1:0]  KIND_PARAM     = 2'h2;

	// Command block: head word then eight character words, word one lowest
	typedef struct packed {
		logic [127:0] chars;
		logic [15:0]  head;
	} dnr_cmd_s;

	// Write request into the name storage
	typedef struct packed {
		logic         en;
		logic         clear;
		logic [4:0]   idx;
		logic [127:0] chars;
	} dnr_wr_s;

endpackage

// ==== core/dnr_name_store.sv ====
`timescale 1ns/1ps
module dnr_name_store (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            resetn,
	// Write side
	input  wire dnr_pkg::dnr_wr_s wr,
	// Read side, combinational
	input  wire logic [4:0]      rd_idx,
	output logic      [127:0]    rd_text,
	output logic                 rd_valid
);

	// ------------------------------------------------------------
	// Storage, one entry per name
	// ------------------------------------------------------------
	logic [127:0]                    text      [dnr_pkg::NUM_ENTRIES];
	logic [127:0]                    next_text [dnr_pkg::NUM_ENTRIES];
	logic [dnr_pkg::NUM_ENTRIES-1:0] valid;
	logic [dnr_pkg::NUM_ENTRIES-1:0] next_valid;

	genvar g;
	generate
		for (g = 0; g < dnr_pkg::NUM_ENTRIES; g++) begin : g_entry
			// Clear wipes text so a stale name cannot leak on re-register
			always_comb begin
				next_text[g]  = text[g];
				next_valid[g] = valid[g];
				if (wr.en && wr.idx == 5'(g)) begin
					next_valid[g] = !wr.clear;
					next_text[g]  = wr.clear ? 128'h0 : wr.chars;
				end
			end
			always_ff @(posedge clk) begin
				if (!resetn) begin
					text[g]  <= 128'h0;
					valid[g] <= 1'b0;
				end else begin
					text[g]  <= next_text[g];
					valid[g] <= next_valid[g];
				end
			end
		end
	endgenerate

	// Out of range indices read as empty
	always_comb begin
		rd_text  = 128'h0;
		rd_valid = 1'b0;
		if (rd_idx < 5'(dnr_pkg::NUM_ENTRIES)) begin
			rd_text  = text[rd_idx];
			rd_valid = valid[rd_idx];
		end
	end

endmodule

// ==== core/dnr_top.sv ====
`timescale 1ns/1ps
module dnr_top (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Registration command
	input  wire logic              cmd_valid,
	input  wire dnr_pkg::dnr_cmd_s cmd,
	output logic                   cmd_busy,
	output logic                   cmd_done,
	output logic                   cmd_err,
	output logic      [15:0]       cmd_err_code,
	// User error trigger word
	input  wire logic              err_trig_we,
	input  wire logic [15:0]       err_trig_data,
	output logic                   user_err_active,
	output logic      [7:0]        user_err_num,
	// Monitor select settings, one byte per user monitor
	input  wire logic [2:0][7:0]   mon_select,
	// Panel read port
	input  wire logic              panel_rd,
	input  wire logic [1:0]        panel_kind,
	input  wire logic [7:0]        panel_num,
	output logic                   panel_ack,
	output logic                   panel_present,
	output logic      [127:0]      panel_text
);

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_EXEC = 2'b10
	} dnr_state_e;

	dnr_state_e        state, next_state;
	dnr_pkg::dnr_cmd_s cmd_q, next_cmd_q;
	logic              next_busy, next_done, next_err;
	logic [15:0]       next_code;
	dnr_pkg::dnr_wr_s  wr;
	logic [6:0]        ty;
	logic [7:0]        sel;
	logic              clr, sel_ok, type_ok, is_name;
	logic [4:0]        idx;
	logic [15:0]       bad_code;

	// Decode of the latched head word
	always_comb begin
		ty       = cmd_q.head[6:0];                          // [RULE17]
		clr      = cmd_q.head[dnr_pkg::CLEAR_BIT];           // [RULE17]
		sel      = cmd_q.head[15:8];
		sel_ok   = 1'b0;
		type_ok  = 1'b1;
		is_name  = 1'b1;
		idx      = 5'h00;
		bad_code = dnr_pkg::ERR_CODE_SEL;
		case (ty)
			dnr_pkg::TYPE_MONITOR: begin                     // [RULE1] [RULE4]
				sel_ok = sel >= dnr_pkg::MON_SEL_FIRST && sel <= dnr_pkg::MON_SEL_LAST;
				idx    = dnr_pkg::IDX_MON_BASE + 5'(sel - dnr_pkg::MON_SEL_FIRST); // [RULE2]
			end
			dnr_pkg::TYPE_ERROR: begin                       // [RULE7] [RULE9]
				sel_ok = sel >= dnr_pkg::ERR_SEL_FIRST && sel <= dnr_pkg::ERR_SEL_LAST;
				idx    = dnr_pkg::IDX_ERR_BASE + 5'(sel - dnr_pkg::ERR_SEL_FIRST);
			end
			dnr_pkg::TYPE_PARAM: begin                       // [RULE11] [RULE13]
				sel_ok   = sel >= dnr_pkg::PAR_SEL_FIRST && sel <= dnr_pkg::PAR_SEL_LAST;
				idx      = dnr_pkg::IDX_PAR_BASE + 5'(sel - dnr_pkg::PAR_SEL_FIRST);
				bad_code = dnr_pkg::ERR_CODE_PAR;            // [RULE12]
			end
			dnr_pkg::TYPE_UNIT: begin
				// Unit names are accepted but not stored by this block
				sel_ok  = 1'b1;
				is_name = 1'b0;
			end
			default: begin
				type_ok = 1'b0;                              // [RULE16]
				is_name = 1'b0;
			end
		endcase
	end

	// Storage write, only for a legal selector; clears drop the text
	always_comb begin
		wr.en    = state == S_EXEC && type_ok && sel_ok && is_name; // [RULE3] [RULE8]
		wr.clear = clr;                                             // [RULE4] [RULE9] [RULE13]
		wr.idx   = idx;
		wr.chars = clr ? 128'h0 : cmd_q.chars;                      // [RULE5] [RULE17]
	end

	// Next state and answer; commands during busy are ignored
	always_comb begin
		next_state = state;
		next_cmd_q = cmd_q;
		next_done  = 1'b0;
		next_err   = 1'b0;
		next_code  = cmd_err_code;
		case (state)
			S_IDLE: begin
				if (cmd_valid) begin
					next_cmd_q = cmd;
					next_state = S_EXEC;
				end
			end
			S_EXEC: begin
				next_state = S_IDLE;
				next_done  = 1'b1;
				next_err   = !(type_ok && sel_ok);                // [RULE3] [RULE8] [RULE12]
				next_code  = (type_ok && sel_ok) ? 16'h0000 : bad_code; // [RULE16]
			end
			default: next_state = S_IDLE;
		endcase
		next_busy = next_state == S_EXEC;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state        <= S_IDLE;
			cmd_q        <= '0;
			cmd_busy     <= 1'b0;
			cmd_done     <= 1'b0;
			cmd_err      <= 1'b0;
			cmd_err_code <= 16'h0000;
		end else begin
			state        <= next_state;
			cmd_q        <= next_cmd_q;
			cmd_busy     <= next_busy;
			cmd_done     <= next_done;
			cmd_err      <= next_err;
			cmd_err_code <= next_code;
		end
	end

	// ------------------------------------------------------------
	// Name storage
	// ------------------------------------------------------------
	logic [4:0]   rd_idx;
	logic [127:0] rd_text;
	logic         rd_valid;

	dnr_name_store u_store (
		.clk      (clk),
		.resetn   (resetn),
		.wr       (wr),
		.rd_idx   (rd_idx),
		.rd_text  (rd_text),
		.rd_valid (rd_valid)
	);

	// ------------------------------------------------------------
	// User error trigger
	// ------------------------------------------------------------
	logic       next_uerr;
	logic [7:0] next_unum;

	// Any write outside the range drops the error again
	always_comb begin
		next_uerr = user_err_active;
		next_unum = user_err_num;
		if (err_trig_we) begin
			next_uerr = err_trig_data >= 16'(dnr_pkg::ERR_SEL_FIRST)
			         && err_trig_data <= 16'(dnr_pkg::ERR_SEL_LAST);  // [RULE10]
			next_unum = next_uerr ? err_trig_data[7:0] : 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			user_err_active <= 1'b0;
			user_err_num    <= 8'h00;
		end else begin
			user_err_active <= next_uerr;
			user_err_num    <= next_unum;
		end
	end

	// ------------------------------------------------------------
	// Panel read with display truncation
	// ------------------------------------------------------------
	logic         p_ok;
	logic [4:0]   p_limit;
	logic         next_ack, next_present;
	logic [127:0] next_ptext;
	logic [7:0]   p_mon;

	// Selector decode of the panel request, same codes as the command
	always_comb begin
		p_ok    = 1'b0;
		rd_idx  = 5'h1f;
		p_limit = dnr_pkg::SHOW_MON_ERR;                         // [RULE6]
		p_mon   = panel_num - dnr_pkg::MON_SEL_FIRST;
		case (panel_kind)
			dnr_pkg::KIND_MONITOR: begin
				// Monitor names only show once the select setting points at them
				p_ok = panel_num >= dnr_pkg::MON_SEL_FIRST && panel_num <= dnr_pkg::MON_SEL_LAST
				    && mon_select[p_mon[1:0]] == panel_num;        // [RULE15]
				rd_idx = dnr_pkg::IDX_MON_BASE + 5'(p_mon);
			end
			dnr_pkg::KIND_ERROR: begin
				p_ok   = panel_num >= dnr_pkg::ERR_SEL_FIRST && panel_num <= dnr_pkg::ERR_SEL_LAST;
				rd_idx = dnr_pkg::IDX_ERR_BASE + 5'(panel_num - dnr_pkg::ERR_SEL_FIRST);
			end
			dnr_pkg::KIND_PARAM: begin
				p_ok    = panel_num >= dnr_pkg::PAR_SEL_FIRST && panel_num <= dnr_pkg::PAR_SEL_LAST;
				rd_idx  = dnr_pkg::IDX_PAR_BASE + 5'(panel_num - dnr_pkg::PAR_SEL_FIRST);
				p_limit = dnr_pkg::SHOW_PAR;                     // [RULE14]
			end
			default: p_ok = 1'b0;
		endcase
	end

	// Characters past the limit read as zero; text holds between reads
	always_comb begin
		next_ack     = panel_rd;
		next_present = panel_present;
		next_ptext   = panel_text;
		if (panel_rd) begin
			next_present = p_ok && rd_valid;
			next_ptext   = 128'h0;
			for (int k = 0; k < dnr_pkg::MAX_CHARS; k++) begin
				if (p_ok && rd_valid && 5'(k) < p_limit) begin     // [RULE6] [RULE14]
					next_ptext[8*k +: 8] = rd_text[8*k +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			panel_ack     <= 1'b0;
			panel_present <= 1'b0;
			panel_text    <= 128'h0;
		end else begin
			panel_ack     <= next_ack;
			panel_present <= next_present;
			panel_text    <= next_ptext;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_mon_map;
		state == S_EXEC && ty == dnr_pkg::TYPE_MONITOR && sel == 8'h29 |-> wr.en && wr.idx == 5'h01;
	endproperty
	a_mon_map: assert property (p_mon_map) else $error("monitor two not mapped"); // [RULE2]

	property p_mon_bad;
		state == S_EXEC && ty == dnr_pkg::TYPE_MONITOR && sel == 8'h2b
			|-> !wr.en ##1 cmd_done && cmd_err && cmd_err_code == 16'h1004;
	endproperty
	a_mon_bad: assert property (p_mon_bad) else $error("bad monitor selector accepted"); // [RULE3]

	property p_mon_clear;
		state == S_EXEC && cmd_q.head == 16'h2a81 |-> wr.en && wr.clear && wr.idx == 5'h02;
	endproperty
	a_mon_clear: assert property (p_mon_clear) else $error("monitor clear missing"); // [RULE4]

	// Checks what landed in storage, not just the request, so a lost write shows
	property p_chars;
		wr.en && !wr.clear |=> u_store.text[$past(wr.idx)] == $past(cmd_q.chars);
	endproperty
	a_chars: assert property (p_chars) else $error("character words altered"); // [RULE5]

	property p_mon_trunc;
		panel_rd && panel_kind == dnr_pkg::KIND_MONITOR |=> panel_ack && panel_text[127:96] == 32'h0;
	endproperty
	a_mon_trunc: assert property (p_mon_trunc) else $error("monitor name over 12 chars"); // [RULE6]

	property p_err_bad;
		state == S_EXEC && ty == dnr_pkg::TYPE_ERROR && (sel < 8'h10 || sel > 8'h14)
			|=> cmd_err && cmd_err_code == 16'h1004;
	endproperty
	a_err_bad: assert property (p_err_bad) else $error("bad error selector accepted"); // [RULE8]

	property p_trig;
		err_trig_we && err_trig_data == 16'h0012 |=> user_err_active && user_err_num == 8'h12;
	endproperty
	a_trig: assert property (p_trig) else $error("user error not raised"); // [RULE10]

	property p_par_bad;
		state == S_EXEC && ty == dnr_pkg::TYPE_PARAM && sel == 8'h0b
			|=> cmd_done && cmd_err_code == 16'h1005;
	endproperty
	a_par_bad: assert property (p_par_bad) else $error("bad parameter selector accepted"); // [RULE12]

	property p_par_trunc;
		panel_rd && panel_kind == dnr_pkg::KIND_PARAM |=> panel_text[127:72] == 56'h0;
	endproperty
	a_par_trunc: assert property (p_par_trunc) else $error("parameter name over 9 chars"); // [RULE14]

	property p_bad_type;
		cmd_valid && state == S_IDLE && cmd.head[6:0] == 7'h05 ##1 1'b1
			|=> cmd_done && cmd_err && cmd_err_code == 16'h1004;
	endproperty
	a_bad_type: assert property (p_bad_type) else $error("bad type accepted"); // [RULE16]

	property p_clear_text;
		wr.en && wr.clear
			|=> !u_store.valid[$past(wr.idx)] && u_store.text[$past(wr.idx)] == 128'h0;
	endproperty
	a_clear_text: assert property (p_clear_text) else $error("clear carried text"); // [RULE17]

	c_mon_ok:   cover property (state == S_EXEC && wr.en && !wr.clear && ty == dnr_pkg::TYPE_MONITOR);
	c_par_ok:   cover property (state == S_EXEC && wr.en && ty == dnr_pkg::TYPE_PARAM);
	c_cmd_err:  cover property (cmd_done && cmd_err);
	c_show:     cover property (panel_ack && panel_present);

endmodule

// ==== tb/dnr_exec_model.sv ====
`timescale 1ns/1ps
module dnr_exec_model (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	// Command request
	output logic                   cmd_valid,
	output dnr_pkg::dnr_cmd_s      cmd,
	input  wire logic              cmd_busy,
	input  wire logic              cmd_done,
	input  wire logic              cmd_err,
	input  wire logic [15:0]       cmd_err_code,
	// Monitor select settings
	output logic      [2:0][7:0]   mon_select
);
	// ------------------------------------------------------------
	// Caller side of the registration command
	// ------------------------------------------------------------
	// Quiet until the bench asks for something
	initial begin
		cmd_valid  = 1'b0;
		cmd        = '0;
		mon_select = '0;
	end

	// Names only show once the selects hold the user monitor codes
	task automatic set_select(input logic good);
		@(negedge clk);
		mon_select = good ? {8'h2a, 8'h29, 8'h28} : {8'h2b, 8'h27, 8'h00};
	endtask

	// One command; stick keeps asking with c2 while busy, which must be ignored
	task automatic issue(input dnr_pkg::dnr_cmd_s c, input int delay, input logic stick,
		input dnr_pkg::dnr_cmd_s c2, output logic err, output logic [15:0] code,
		output logic ok, output logic busy);
		repeat (delay) @(negedge clk);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd       = c;
		@(negedge clk);
		busy = cmd_busy;
		if (stick) begin
			cmd = c2;
		end else begin
			cmd_valid = 1'b0;
			cmd       = ~c;	// Released lines do not keep the old value
		end
		// Answer lands exactly one cycle after the taking edge
		@(negedge clk);
		ok        = cmd_done;
		err       = cmd_err;
		code      = cmd_err_code;
		cmd_valid = 1'b0;
		cmd       = ~c;
	endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(what, exp, got) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			fails++; \
			$display("Error %s expected %h seen %h", what, exp, got); \
		end \
	end

module tb_top;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                  clk;
	logic                  resetn;
	logic                  cmd_valid;
	dnr_pkg::dnr_cmd_s     cmd;
	logic                  cmd_busy;
	logic                  cmd_done;
	logic                  cmd_err;
	logic      [15:0]      cmd_err_code;
	logic                  err_trig_we;
	logic      [15:0]      err_trig_data;
	logic                  user_err_active;
	logic      [7:0]       user_err_num;
	logic      [2:0][7:0]  mon_select;
	logic                  panel_rd;
	logic      [1:0]       panel_kind;
	logic      [7:0]       panel_num;
	logic                  panel_ack;
	logic                  panel_present;
	logic      [127:0]     panel_text;
	int                    fails;
	int                    num_checks;
	logic      [127:0]     names [18];
	logic                  pres  [18];
	logic                  sel_ok;
	int                    k;
	int                    s;
	int                    lo    [3] = '{8'h28, 8'h10, 8'h01};
	int                    hi    [3] = '{8'h2a, 8'h14, 8'h0a};
	logic      [7:0]       bad_ty [8] = '{8'h00, 8'h05, 8'h7f, 8'h80, 8'h85, 8'hff, 8'h04, 8'h84};
	logic      [15:0]      trig_v [6] = '{16'h000f, 16'h0010, 16'h0014, 16'h0015,
		16'h1010, 16'h0012};

	dnr_top DUT (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_err(cmd_err),
		.cmd_err_code(cmd_err_code), .err_trig_we(err_trig_we),
		.err_trig_data(err_trig_data), .user_err_active(user_err_active),
		.user_err_num(user_err_num), .mon_select(mon_select), .panel_rd(panel_rd),
		.panel_kind(panel_kind), .panel_num(panel_num), .panel_ack(panel_ack),
		.panel_present(panel_present), .panel_text(panel_text));

	dnr_exec_model u_exec (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_err_code(cmd_err_code),
		.mon_select(mon_select));

	// 25 MHz
	always #20 clk = ~clk;

	// ------------------------------------------------------------
	// Expectations
	// ------------------------------------------------------------
	// Type is checked before the selector; unit type takes any selector
	function automatic logic [15:0] exp_code(input logic [15:0] h);
		case (h[6:0])
			7'h01: return (h[15:8] >= 8'h28 && h[15:8] <= 8'h2a) ? 16'h0000 : 16'h1004;
			7'h02: return (h[15:8] >= 8'h10 && h[15:8] <= 8'h14) ? 16'h0000 : 16'h1004;
			7'h03: return (h[15:8] >= 8'h01 && h[15:8] <= 8'h0a) ? 16'h0000 : 16'h1005;
			7'h04: return 16'h0000;
			default: return 16'h1004;
		endcase
	endfunction

	function automatic int slot(input logic [6:0] t, input logic [7:0] n);
		case (t)
			7'h01: return int'(n) - 8'h28;
			7'h02: return 3 + int'(n) - 8'h10;
			default: return 7 + int'(n);
		endcase
	endfunction

	// Panel keeps only the first n characters
	function automatic logic [127:0] shown(input logic [127:0] c, input int n);
		return c & ((128'h1 << (8 * n)) - 128'h1);
	endfunction

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic do_cmd(input logic [15:0] h, input logic stick);
		dnr_pkg::dnr_cmd_s c;
		dnr_pkg::dnr_cmd_s c2;
		logic              err;
		logic              ok;
		logic              busy;
		logic [15:0]       code;
		logic [15:0]       e;
		c.head   = h;
		c.chars  = {$urandom, $urandom, $urandom, $urandom};
		c2.head  = {h[15:8], 1'b1, h[6:0]};	// A clear that would erase the entry
		c2.chars = ~c.chars;
		e        = exp_code(h);
		u_exec.issue(c, $urandom_range(2), stick, c2, err, code, ok, busy);
		`CHK("cmd_busy", 1'b1, busy)
		`CHK("cmd_done", 1'b1, ok)
		`CHK("cmd_err_code", e, code)
		`CHK("cmd_err", e != 16'h0000, err)
		if (e == 16'h0000 && h[6:0] != 7'h04) begin
			pres[slot(h[6:0], h[15:8])]  = !h[7];
			names[slot(h[6:0], h[15:8])] = h[7] ? 128'h0 : c.chars;
		end
	endtask

	task automatic do_read(input logic [1:0] kd, input logic [7:0] n);
		logic [6:0]   typ;
		logic         vis;
		logic [127:0] t;
		typ = 7'(kd) + 7'h01;
		vis = 1'b0;
		if (kd != 2'h3 && exp_code({n, 1'b0, typ}) == 16'h0000)
			vis = pres[slot(typ, n)] && (kd != 2'h0 || sel_ok);
		t = vis ? shown(names[slot(typ, n)], kd == 2'h2 ? 9 : 12) : 128'h0;
		@(negedge clk);
		panel_rd   = 1'b1;
		panel_kind = kd;
		panel_num  = n;
		@(negedge clk);
		panel_rd   = 1'b0;
		panel_kind = ~kd;
		panel_num  = ~n;
		`CHK("panel_ack", 1'b1, panel_ack)
		`CHK("panel_present", vis, panel_present)
		`CHK("panel_text", t, panel_text)
	endtask

	task automatic do_trig(input logic [15:0] d);
		logic hit;
		hit = d >= 16'h0010 && d <= 16'h0014;
		@(negedge clk);
		err_trig_we   = 1'b1;
		err_trig_data = d;
		@(negedge clk);
		err_trig_we   = 1'b0;
		err_trig_data = ~d;
		`CHK("user_err_active", hit, user_err_active)
		`CHK("user_err_num", hit ? d[7:0] : 8'h00, user_err_num)
	endtask

	// Every table selector plus its neighbours; mode 0 write, 1 read, 2 clear
	task automatic sweep(input int mode);
		for (int t = 0; t < 3; t++)
			for (int n = lo[t] - 1; n <= hi[t] + 1; n++)
				if (mode == 1)
					do_read(2'(t), 8'(n));
				else
					do_cmd({8'(n), mode == 2, 7'(t + 1)}, 1'b0);
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("Error watchdog expected finish seen hang");
		complete_run();
	end

	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		err_trig_we = 1'b0;
		err_trig_data = 16'h0000;
		panel_rd = 1'b0;
		panel_kind = 2'h0;
		panel_num = 8'h00;
		fails = 0;
		num_checks = 0;
		sel_ok = 1'b1;
		foreach (pres[i]) begin
			pres[i] = 1'b0;
			names[i] = 128'h0;
		end
		void'($urandom(22));
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		`CHK("cmd_done", 1'b0, cmd_done)
		`CHK("cmd_err_code", 16'h0000, cmd_err_code)
		`CHK("user_err_active", 1'b0, user_err_active)
		u_exec.set_select(1'b1);
		end_test("reset");
		sweep(0);
		sweep(1);
		end_test("register");
		u_exec.set_select(1'b0);
		sel_ok = 1'b0;
		sweep(1);
		u_exec.set_select(1'b1);
		sel_ok = 1'b1;
		end_test("select");
		foreach (lo[t]) begin
			do_cmd({8'(lo[t]), 8'(t + 1)}, 1'b1);
			do_read(2'(t), 8'(lo[t]));
		end
		end_test("busy");
		foreach (bad_ty[i])
			do_cmd({8'(lo[0]), bad_ty[i]}, 1'b0);
		for (int t = 0; t < 8; t++)
			do_cmd({8'($urandom_range(8'h2a)), t[2] ? 8'h84 : 8'h04}, 1'b0);
		do_cmd({8'h28, 8'h7f}, 1'b0);
		do_cmd({8'h10, 8'h85}, 1'b0);
		sweep(1);
		end_test("types");
		sweep(2);
		sweep(1);
		end_test("clear");
		foreach (trig_v[i])
			do_trig(trig_v[i]);
		end_test("trigger");
		for (int i = 0; i < 120; i++) begin
			k = $urandom_range(2);
			s = lo[k] - 2 + $urandom_range(hi[k] - lo[k] + 4);
			case ($urandom_range(3))
				0: do_cmd({8'(s), 1'($urandom_range(1)), 7'(k + 1)}, 1'($urandom_range(1)));
				1: do_read(2'($urandom_range(3)), 8'(s));
				2: do_trig(16'($urandom_range(8'h18)));
				default: do_cmd(16'($urandom), 1'b0);
			endcase
		end
		sweep(1);
		end_test("random");
		@(negedge clk);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		foreach (pres[i]) pres[i] = 1'b0;
		`CHK("user_err_active", 1'b0, user_err_active)
		sweep(1);
		end_test("second reset");
		complete_run();
	end
endmodule
